// >>> src/ptb_time_base.sv
`timescale 1ns/1ps
module ptb_time_base
    import ptb_pkg::*;
(
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    input  wire ptb_ctrl_s        ctrlWrData,
    input  wire logic             ctrlWr,
    input  wire logic [CNT_W-1:0] counterWrData,
    input  wire logic             counterWr,
    input  wire logic [CNT_W-1:0] periodWrData,
    input  wire logic             periodWr,
    output logic [15:0]           timeBaseCounter,
    output logic                  timeBaseEnable,
    output logic [CNT_W-1:0]      periodValue,
    output logic                  timeBaseIrq
);
    ptb_state_s st_reg;
    ptb_state_s st_next;
    logic [1:0] mode_reg;
    logic [1:0] preSel_reg;
    logic [3:0] postSel_reg;
    logic       tick;
    logic       clrScale;
    logic       match;
    logic       atZero;
    logic       postEvt;

    assign clrScale = ctrlWr || counterWr;
    assign match = (st_reg.count == st_reg.period) && (st_reg.period != PER_RESET);
    assign atZero = (st_reg.count == CNT_RESET);

    ptb_prescaler u_pre
    (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .clear   (clrScale),
        .run     (st_reg.enable && (st_reg.period != PER_RESET)),
        .sel     (preSel_reg),
        .tick    (tick)
    );

    assign mode_reg = st_reg.mode;
    assign preSel_reg = st_reg.prescaleSel;
    assign postSel_reg = st_reg.postscaleSel;

    always_comb
    begin
        st_next = st_reg;
        st_next.irq = 1'b0;
        postEvt = 1'b0;
        if (periodWr)
            st_next.periodBuf = periodWrData;
        if (ctrlWr)
        begin
            st_next.enable = ctrlWrData.enable;
            st_next.mode = ctrlWrData.mode;
            st_next.prescaleSel = ctrlWrData.prescaleSel;
            st_next.postscaleSel = ctrlWrData.postscaleSel;
        end
        if (tick && st_reg.period != PER_RESET)
        begin
            case (mode_reg)
                MODE_FREE, MODE_SHOT:
                begin
                    if (match)
                    begin
                        st_next.count = CNT_RESET;
                        st_next.period = st_reg.periodBuf;
                        if (mode_reg == MODE_SHOT)
                        begin
                            st_next.enable = 1'b0;
                            st_next.irq = 1'b1;
                        end
                        else
                            postEvt = 1'b1;
                    end
                    else
                        st_next.count = st_reg.count + 15'h0001;
                    st_next.countDown = 1'b0;
                end
                MODE_UPDN, MODE_DBL:
                begin
                    if (!st_reg.countDown)
                    begin
                        if (match)
                        begin
                            st_next.countDown = 1'b1;
                            st_next.count = st_reg.count - 15'h0001;
                            if (mode_reg == MODE_DBL)
                                st_next.irq = 1'b1;
                        end
                        else
                            st_next.count = st_reg.count + 15'h0001;
                    end
                    else if (atZero)
                    begin
                        st_next.countDown = 1'b0;
                        st_next.count = 15'h0001;
                        st_next.period = st_reg.periodBuf;
                        if (mode_reg == MODE_DBL)
                            st_next.irq = 1'b1;
                        else
                            postEvt = 1'b1;
                    end
                    else
                    begin
                        st_next.count = st_reg.count - 15'h0001;
                        if (st_reg.count == 15'h0001 && mode_reg == MODE_DBL)
                            st_next.irq = 1'b0;
                    end
                end
                default:
                    st_next.count = st_reg.count;
            endcase
        end
        // Postscaler divides the free-running and plain up/down events
        if (clrScale)
            st_next.postCnt = POST_RESET;
        else if (postEvt)
        begin
            if (st_reg.postCnt >= postSel_reg)
            begin
                st_next.postCnt = POST_RESET;
                st_next.irq = 1'b1;
            end
            else
                st_next.postCnt = st_reg.postCnt + 4'h1;
        end
        if (counterWr)
            st_next.count = counterWrData;
        // Buffer loads while disabled, never while period is zero and enabled
        if (!st_reg.enable)
            st_next.period = st_reg.periodBuf;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg.count <= CNT_RESET;
            st_reg.countDown <= 1'b0;
            st_reg.enable <= 1'b0;
            st_reg.period <= PER_RESET;
            st_reg.periodBuf <= PER_RESET;
            st_reg.postCnt <= POST_RESET;
            st_reg.irq <= 1'b0;
            st_reg.mode <= MODE_RESET;
            st_reg.prescaleSel <= PRESEL_RESET;
            st_reg.postscaleSel <= POSTSEL_RESET;
        end
        else
            st_reg <= st_next;
    end

    assign timeBaseCounter = {st_reg.countDown, st_reg.count};
    assign timeBaseEnable = st_reg.enable;
    assign periodValue = st_reg.period;
    assign timeBaseIrq = st_reg.irq;

    // Sequences shared by the mode checks
    sequence seq_shot_match;
        tick && match && mode_reg == MODE_SHOT && !ctrlWr;
    endsequence
    sequence seq_updn_match;
        tick && match && !st_reg.countDown && mode_reg[1];
    endsequence
    sequence seq_zero_turn;
        tick && st_reg.countDown && atZero && mode_reg[1];
    endsequence

    a_period_zero_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (st_reg.period == PER_RESET && !counterWr) |=> $stable(st_reg.count))
        else $error("Counter moved with zero period");
    a_shot_clears_en: assert property (@(posedge sys_clk) disable iff (!rst_n)
        seq_shot_match |=> !st_reg.enable && st_reg.irq)
        else $error("Single-shot did not stop");
    a_free_wrap: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (tick && match && mode_reg == MODE_FREE && !counterWr) |=> st_reg.count == CNT_RESET)
        else $error("Free-running did not wrap");
    a_updn_turn: assert property (@(posedge sys_clk) disable iff (!rst_n)
        seq_updn_match |=> st_reg.countDown)
        else $error("Up/down did not turn at match");
    a_disable_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!st_reg.enable && !counterWr) |=> $stable(st_reg.count))
        else $error("Counter moved while disabled");
    a_dbl_match_irq: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (tick && match && !st_reg.countDown && mode_reg == MODE_DBL) |=> st_reg.irq)
        else $error("Double update missed match event");
    a_dir_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (tick && timeBaseCounter[DIR_BIT] && !atZero && mode_reg[1])
        |=> st_reg.count == $past(st_reg.count) - 15'h0001)
        else $error("Direction bit wrong");
    a_scale_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ctrlWr |=> st_reg.postCnt == POST_RESET)
        else $error("Postscaler not cleared");
    a_zero_no_irq: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (st_reg.period == PER_RESET) |=> !st_reg.irq)
        else $error("Event raised with zero period");
    a_shot_one_event: assert property (@(posedge sys_clk) disable iff (!rst_n)
        seq_shot_match |=> st_reg.irq ##1 !st_reg.irq)
        else $error("Single-shot event not a single pulse");
    a_zero_turn_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
        seq_zero_turn
        |=> !st_reg.countDown && st_reg.period == $past(st_reg.periodBuf))
        else $error("Period not reloaded at zero turn");
    a_updn_zero_event: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (tick && st_reg.countDown && atZero && mode_reg == MODE_UPDN
            && st_reg.postCnt >= postSel_reg) |=> st_reg.irq)
        else $error("Up/down missed zero event");
    a_dbl_zero_irq: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (tick && st_reg.countDown && atZero && mode_reg == MODE_DBL)
        |=> st_reg.irq)
        else $error("Double update missed zero event");
    a_free_event: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (tick && match && mode_reg == MODE_FREE && st_reg.postCnt >= postSel_reg)
        |=> st_reg.irq)
        else $error("Free-running missed match event");
    a_free_count_up: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (tick && !match && mode_reg == MODE_FREE)
        |=> st_reg.count == $past(st_reg.count) + 15'h0001 && !st_reg.countDown)
        else $error("Free-running did not count up");
    a_prescale_gap: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (tick && preSel_reg == 2'h1)
        |=> (!tick || preSel_reg != 2'h1) [*3])
        else $error("Prescaler ticked early at one in four");
    a_ctrl_keeps_count: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ctrlWr && !counterWr) |=> $stable(st_reg.count))
        else $error("Control write moved the counter");
endmodule

// >>> pkg/ptb_pkg.sv
package ptb_pkg;
    localparam int CNT_W = 15;
    localparam int DIR_BIT = 15;
    localparam logic [1:0] MODE_FREE = 2'h0;
    localparam logic [1:0] MODE_SHOT = 2'h1;
    localparam logic [1:0] MODE_UPDN = 2'h2;
    localparam logic [1:0] MODE_DBL = 2'h3;
    localparam logic [CNT_W-1:0] CNT_RESET = 15'h0000;
    localparam logic [CNT_W-1:0] PER_RESET = 15'h0000;
    localparam logic [1:0] MODE_RESET = 2'h0;
    localparam logic [5:0] PRE_RESET = 6'h00;
    localparam logic [3:0] POST_RESET = 4'h0;
    localparam logic [1:0] PRESEL_RESET = 2'h0;
    localparam logic [3:0] POSTSEL_RESET = 4'h0;
    localparam logic [5:0] PRE_LAST_DIV1 = 6'h00;
    localparam logic [5:0] PRE_LAST_DIV4 = 6'h03;
    localparam logic [5:0] PRE_LAST_DIV16 = 6'h0F;
    localparam logic [5:0] PRE_LAST_DIV64 = 6'h3F;

    typedef struct packed {
        logic       enable;
        logic [1:0] mode;
        logic [1:0] prescaleSel;
        logic [3:0] postscaleSel;
    } ptb_ctrl_s;

    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic             countDown;
        logic             enable;
        logic [CNT_W-1:0] period;
        logic [CNT_W-1:0] periodBuf;
        logic [3:0]       postCnt;
        logic             irq;
        logic [1:0]       mode;
        logic [1:0]       prescaleSel;
        logic [3:0]       postscaleSel;
    } ptb_state_s;
endpackage

// >>> src/ptb_prescaler.sv
`timescale 1ns/1ps
module ptb_prescaler
    import ptb_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       clear,
    input  wire logic       run,
    input  wire logic [1:0] sel,
    output logic            tick
);
    logic [5:0] preCnt_reg;
    logic [5:0] preCnt_next;
    logic [5:0] lastCnt;

    always_comb
    begin
        case (sel)
            2'h0: lastCnt = PRE_LAST_DIV1;
            2'h1: lastCnt = PRE_LAST_DIV4;
            2'h2: lastCnt = PRE_LAST_DIV16;
            default: lastCnt = PRE_LAST_DIV64;
        endcase
        preCnt_next = preCnt_reg;
        tick = 1'b0;
        if (clear)
            preCnt_next = PRE_RESET;
        else if (run)
        begin
            if (preCnt_reg >= lastCnt)
            begin
                preCnt_next = PRE_RESET;
                tick = 1'b1;
            end
            else
                preCnt_next = preCnt_reg + 6'h01;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            preCnt_reg <= PRE_RESET;
        else
            preCnt_reg <= preCnt_next;
    end
endmodule

// >>> sim/test_ptb_time_base.sv
`timescale 1ns/1ps
module test_ptb_time_base;
    import ptb_pkg::*;
    logic             sys_clk = 1'b0;
    logic             rst_n;
    ptb_ctrl_s        ctrlWrData;
    logic             ctrlWr;
    logic [CNT_W-1:0] counterWrData;
    logic             counterWr;
    logic [CNT_W-1:0] periodWrData;
    logic             periodWr;
    logic [15:0]      timeBaseCounter;
    logic             timeBaseEnable;
    logic [CNT_W-1:0] periodValue;
    logic             timeBaseIrq;
    logic [15:0]      irqTotal = 16'h0000;
    logic [15:0]      irqBase;
    logic [15:0]      held;
    int               fail_count = 0;
    int               check_count = 0;

    ptb_time_base dut (.sys_clk(sys_clk), .rst_n(rst_n), .ctrlWrData(ctrlWrData),
        .ctrlWr(ctrlWr), .counterWrData(counterWrData), .counterWr(counterWr),
        .periodWrData(periodWrData), .periodWr(periodWr), .timeBaseCounter(timeBaseCounter),
        .timeBaseEnable(timeBaseEnable), .periodValue(periodValue), .timeBaseIrq(timeBaseIrq));

    always #4 sys_clk = ~sys_clk;

    // Pulses are counted mid-cycle so a one-cycle event is never missed
    always @(negedge sys_clk)
    begin
        if (timeBaseIrq === 1'b1)
            irqTotal <= irqTotal + 16'h0001;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic wr_ctrl(input logic en, input logic [1:0] md, input logic [1:0] pre,
                           input logic [3:0] post);
        ctrlWrData = '{en, md, pre, post};
        ctrlWr = 1'b1;
        tick(1);
        ctrlWr = 1'b0;
    endtask

    task automatic wr_period(input logic [CNT_W-1:0] v);
        periodWrData = v;
        periodWr = 1'b1;
        tick(1);
        periodWr = 1'b0;
    endtask

    // Stop, load period and count zero, then run; irq tally restarts at the run edge
    task automatic start(input logic [1:0] md, input logic [1:0] pre, input logic [3:0] post,
                         input logic [CNT_W-1:0] per);
        wr_ctrl(1'b0, md, pre, post);
        wr_period(per);
        counterWrData = 15'h0000;
        counterWr = 1'b1;
        tick(1);
        counterWr = 1'b0;
        wr_ctrl(1'b1, md, pre, post);
        irqBase = irqTotal;
    endtask

    task automatic test_free();
        start(MODE_FREE, 2'h0, 4'h0, 15'h0002);
        check(timeBaseCounter, 16'h0000);
        tick(1);
        check(timeBaseCounter, 16'h0001);
        tick(1);
        check(timeBaseCounter, 16'h0002);
        tick(1);
        check(timeBaseCounter, 16'h0000);
        tick(8);
        check(irqTotal - irqBase, 16'h0003);
        start(MODE_FREE, 2'h0, 4'h1, 15'h0002);
        tick(20);
        check(irqTotal - irqBase, 16'h0003);
        wr_period(15'h0005);
        check({1'b0, periodValue}, 16'h0002);
        tick(4);
        check({1'b0, periodValue}, 16'h0005);
        wr_ctrl(1'b0, MODE_FREE, 2'h0, 4'h0);
        held = timeBaseCounter;
        tick(5);
        check(timeBaseCounter, held);
        check({15'h0000, timeBaseEnable}, 16'h0000);
        $display("free-running test done");
    endtask

    task automatic test_shot();
        start(MODE_SHOT, 2'h0, 4'h3, 15'h0003);
        check({15'h0000, timeBaseEnable}, 16'h0001);
        tick(8);
        check({15'h0000, timeBaseEnable}, 16'h0000);
        check(timeBaseCounter, 16'h0000);
        check(irqTotal - irqBase, 16'h0001);
        $display("single-shot test done");
    endtask

    task automatic test_updown();
        for (int m = 0; m < 2; m++)
        begin
            start(m == 0 ? MODE_UPDN : MODE_DBL, 2'h0, 4'h0, 15'h0003);
            tick(4);
            check(timeBaseCounter, 16'h8002);
            tick(11);
            check(irqTotal - irqBase, m == 0 ? 16'h0002 : 16'h0004);
        end
        $display("up/down test done");
    endtask

    task automatic test_zero_period();
        start(MODE_FREE, 2'h0, 4'h0, 15'h0000);
        tick(10);
        check(timeBaseCounter, 16'h0000);
        check(irqTotal - irqBase, 16'h0000);
        wr_period(15'h0005);
        tick(2);
        check({1'b0, periodValue}, 16'h0000);
        wr_ctrl(1'b0, MODE_FREE, 2'h0, 4'h0);
        tick(1);
        check({1'b0, periodValue}, 16'h0005);
        $display("zero period test done");
    endtask

    // Reset in mid-run must clear the count, the enable and the active period
    task automatic test_reset();
        start(MODE_UPDN, 2'h1, 4'h0, 15'h0007);
        tick(20);
        check(timeBaseCounter, 16'h0005);
        rst_n = 1'b0;
        tick(2);
        check(timeBaseCounter, 16'h0000);
        check({15'h0000, timeBaseEnable}, 16'h0000);
        check({1'b0, periodValue}, 16'h0000);
        rst_n = 1'b1;
        tick(1);
        $display("reset test done");
    endtask

    task automatic test_prescale();
        for (int i = 0; i < 4; i++)
        begin
            start(MODE_FREE, i[1:0], 4'h0, 15'h0064);
            tick(3 << (2 * i));
            check(timeBaseCounter, 16'h0003);
        end
        $display("prescale test done");
    endtask

    task automatic finish_test();
        $display("checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        #20000;
        fail_count++;
        finish_test();
    end

    initial
    begin
        rst_n = 1'b0;
        ctrlWrData = '0;
        ctrlWr = 1'b0;
        counterWrData = 15'h0000;
        counterWr = 1'b0;
        periodWrData = 15'h0000;
        periodWr = 1'b0;
        irqBase = 16'h0000;
        tick(8);
        check(timeBaseCounter, 16'h0000);
        check({15'h0000, timeBaseEnable}, 16'h0000);
        rst_n = 1'b1;
        tick(1);
        test_free();
        test_shot();
        test_updown();
        test_zero_period();
        test_reset();
        test_prescale();
        finish_test();
    end
endmodule
